// ---- eao_flash_model.sv ----
// Far-side model: a flash unit watching line one and a neighbour sharing line two.
`timescale 1ns/1ns
module eao_flash_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic line_i,
    output logic [7:0] flashes_o,
    output logic [7:0] width_o,
    output logic far_drive_o
);
    logic prev_q;
    logic [7:0] cnt_q;

    // Line two has no pull, so a released wire must not keep its last value.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            far_drive_o <= 1'b0;
        end else begin
            far_drive_o <= ~far_drive_o;
        end
    end

    // The flash fires on each rising edge and the width is kept in clock cycles.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
            flashes_o <= 8'h00;
            width_o <= 8'h00;
        end else begin
            prev_q <= line_i;
            if (line_i) begin
                cnt_q <= cnt_q + 8'h01;
            end
            if (line_i && !prev_q) begin
                flashes_o <= flashes_o + 8'h01;
            end
            if (!line_i && prev_q) begin
                width_o <= cnt_q;
                cnt_q <= 8'h00;
            end
        end
    end
endmodule : eao_flash_model

// ---- eao_lag.sv ----
// Fixed-length delay line for the exposure level.
`timescale 1ns/1ns
module eao_lag #(
    parameter int unsigned DEPTH = 3
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic d_i,
    output logic q_o
);
    logic [DEPTH-1:0] sh_q;
    logic [DEPTH:0] nxt;

    generate
        if (DEPTH < 1) begin : g_bad_depth
            $error("eao_lag needs DEPTH of at least one");
        end
    endgenerate

    assign nxt = {sh_q, d_i};

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sh_q <= '0;
        end else begin
            sh_q <= nxt[DEPTH-1:0];
        end
    end

    assign q_o = sh_q[DEPTH-1];
endmodule : eao_lag

// ---- eao_pkg.sv ----
// Shared constants and types for the exposure active output block.
package eao_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam int unsigned ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_SHUTTER = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PICKER = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_LINE_CFG = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0c;

    // Field positions.
    localparam int unsigned SHUTTER_BIT = 0;
    localparam int unsigned PICKER_BIT = 0;
    localparam int unsigned DIR_BIT = 0;
    localparam int unsigned ORIGIN_LSB = 4;
    localparam int unsigned ORIGIN_W = 2;
    localparam int unsigned ST_EXP_OUT_BIT = 0;
    localparam int unsigned ST_EXP_RAW_BIT = 1;
    localparam int unsigned ST_LINE_TWO_IN_BIT = 2;
    localparam int unsigned ST_SHUTTER_BIT = 3;

    typedef enum logic [0:0] {
        EAO_SHUTTER_GLOBAL = 1'h0,
        EAO_SHUTTER_ROLLING = 1'h1
    } eao_shutter_t;

    typedef enum logic [0:0] {
        EAO_PICK_LINE_ONE = 1'h0,
        EAO_PICK_LINE_TWO = 1'h1
    } eao_picker_t;

    typedef enum logic [1:0] {
        EAO_ORIGIN_OFF = 2'h0,
        EAO_ORIGIN_EXPOSURE = 2'h1
    } eao_origin_t;

    // Reset values.
    localparam eao_shutter_t RST_SHUTTER = EAO_SHUTTER_GLOBAL;
    localparam eao_picker_t RST_PICKER = EAO_PICK_LINE_ONE;
    localparam eao_origin_t RST_ORIGIN = EAO_ORIGIN_OFF;
    localparam logic RST_DIR = 1'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Lag between the sensor event and the edge on the output.
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned EXP_LAG_NS = 60;
    localparam int unsigned LAG_CYCLES = (EXP_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : eao_pkg

// ---- eao_top.sv ----
// Exposure active generator with output line routing and an AXI4-Lite slave.
//
// Operation
// [RULE_01] Global shutter: output rises when each frame's exposure time begins.
// [RULE_02] Global shutter: output falls when that frame's exposure time ends.
// [RULE_03] Rolling shutter: output rises when the first line starts exposing.
// [RULE_04] Rolling shutter: output falls only when the last line ends exposing; here a write that switches the shutter mode also ends it.
// [RULE_05] Rolling timing used only in rolling mode, global timing only in global mode.
// [RULE_06] Output edges lag the real exposure start and end by a fixed delay.
// [RULE_07] Exposure active may be chosen as the source of an output line.
// [RULE_08] Without a general purpose line, software picks line one, then sets its source.
// [RULE_09] With a general purpose line, software first picks line two.
// [RULE_10] Software sets line two to output, then sets its source.
// [RULE_11] Software accounts for any automatic sensor exposure offset when setting up.
// [RULE_12] Output stays low when no exposure runs, after reset and between frames.
`timescale 1ns/1ns
module eao_top #(
    parameter int unsigned LAG_CYCLES = eao_pkg::LAG_CYCLES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    // Sensor timing events, one-cycle pulses.
    input wire logic frame_exp_start_i,
    input wire logic frame_exp_end_i,
    input wire logic first_line_exp_start_i,
    input wire logic last_line_exp_end_i,
    // Camera lines.
    output logic output_line_one_o,
    input wire logic bidirectional_line_two_i,
    output logic bidirectional_line_two_o,
    output logic bidirectional_line_two_oe_o,
    output logic exposure_in_progress_out_o,
    // AXI4-Lite slave.
    input wire logic [eao_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [eao_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    localparam int LAG_I = LAG_CYCLES;
    localparam int LAG_P1 = LAG_CYCLES + 1;
    localparam int unsigned IDLE_W = $clog2(LAG_CYCLES + 1);
    generate
        if (LAG_CYCLES < 1) begin : g_bad_lag
            $error("eao_top needs LAG_CYCLES of at least one");
        end
    endgenerate
    eao_pkg::eao_shutter_t shutter_q;
    eao_pkg::eao_picker_t picker_q;
    eao_pkg::eao_origin_t origin_one_q, origin_two_q;
    logic dir_two_q, exp_q, exp_lag, start_ev, end_ev, mode_chg;
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q, do_wr, wr_lane0, rd_hit, wr_hit;
    logic [eao_pkg::ADDR_W-1:0] aw_addr_q, wr_ofs, rd_ofs;
    logic [31:0] w_data_q, rdata_q, rd_word, line_cfg_word;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic line_one_q, line_two_q, line_two_oe_q;
    logic [IDLE_W-1:0] idle_cnt_q;
    // Write channel: address and data are taken independently, then applied together.
    assign s_axi_awready_o = !aw_have_q && !bvalid_q;
    assign s_axi_wready_o = !w_have_q && !bvalid_q;
    assign do_wr = aw_have_q && w_have_q;
    assign wr_lane0 = do_wr && w_strb_q[0];
    assign wr_ofs = {aw_addr_q[eao_pkg::ADDR_W-1:2], 2'h0};
    assign wr_hit = (wr_ofs == eao_pkg::OFS_SHUTTER) || (wr_ofs == eao_pkg::OFS_PICKER) ||
                    (wr_ofs == eao_pkg::OFS_LINE_CFG) || (wr_ofs == eao_pkg::OFS_STATUS);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            aw_have_q <= 1'h0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'h1;
            aw_addr_q <= s_axi_awaddr_i;
        end else if (do_wr) begin
            aw_have_q <= 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            w_have_q <= 1'h0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'h1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
        end else if (do_wr) begin
            w_have_q <= 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bvalid_q <= 1'h0;
            bresp_q <= eao_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'h1;
            bresp_q <= wr_hit ? eao_pkg::RESP_OKAY : eao_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'h0;
        end
    end
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    // Control registers. Line one is output only, so only line two has a direction.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            shutter_q <= eao_pkg::RST_SHUTTER;
        end else if (wr_lane0 && wr_ofs == eao_pkg::OFS_SHUTTER) begin
            shutter_q <= eao_pkg::eao_shutter_t'(w_data_q[eao_pkg::SHUTTER_BIT]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            picker_q <= eao_pkg::RST_PICKER;
        end else if (wr_lane0 && wr_ofs == eao_pkg::OFS_PICKER) begin
            picker_q <= eao_pkg::eao_picker_t'(w_data_q[eao_pkg::PICKER_BIT]); // see [RULE_08] [RULE_09]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            origin_one_q <= eao_pkg::RST_ORIGIN;
            origin_two_q <= eao_pkg::RST_ORIGIN;
            dir_two_q <= eao_pkg::RST_DIR;
        end else if (wr_lane0 && wr_ofs == eao_pkg::OFS_LINE_CFG) begin
            // The configuration lands on whichever line is currently picked.
            if (picker_q == eao_pkg::EAO_PICK_LINE_ONE) begin
                origin_one_q <= eao_pkg::eao_origin_t'(
                    w_data_q[eao_pkg::ORIGIN_LSB +: eao_pkg::ORIGIN_W]); // see [RULE_08]
            end else begin
                origin_two_q <= eao_pkg::eao_origin_t'(
                    w_data_q[eao_pkg::ORIGIN_LSB +: eao_pkg::ORIGIN_W]); // see [RULE_10]
                dir_two_q <= w_data_q[eao_pkg::DIR_BIT]; // see [RULE_10]
            end
        end
    end

    // Read channel: one word in flight, answered one cycle after the address is taken.
    assign s_axi_arready_o = !rvalid_q;
    assign rd_ofs = {s_axi_araddr_i[eao_pkg::ADDR_W-1:2], 2'h0};
    always_comb begin
        line_cfg_word = '0;
        if (picker_q == eao_pkg::EAO_PICK_LINE_ONE) begin
            line_cfg_word[eao_pkg::DIR_BIT] = 1'h1;
            line_cfg_word[eao_pkg::ORIGIN_LSB +: eao_pkg::ORIGIN_W] = origin_one_q;
        end else begin
            line_cfg_word[eao_pkg::DIR_BIT] = dir_two_q;
            line_cfg_word[eao_pkg::ORIGIN_LSB +: eao_pkg::ORIGIN_W] = origin_two_q;
        end
    end
    always_comb begin
        rd_word = '0;
        rd_hit = 1'h1;
        unique case (rd_ofs)
            eao_pkg::OFS_SHUTTER: rd_word[eao_pkg::SHUTTER_BIT] = shutter_q;
            eao_pkg::OFS_PICKER: rd_word[eao_pkg::PICKER_BIT] = picker_q;
            eao_pkg::OFS_LINE_CFG: rd_word = line_cfg_word;
            eao_pkg::OFS_STATUS: begin
                rd_word[eao_pkg::ST_EXP_OUT_BIT] = exp_lag;
                rd_word[eao_pkg::ST_EXP_RAW_BIT] = exp_q;
                rd_word[eao_pkg::ST_LINE_TWO_IN_BIT] = bidirectional_line_two_i;
                rd_word[eao_pkg::ST_SHUTTER_BIT] = shutter_q;
            end
            default: rd_hit = 1'h0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rvalid_q <= 1'h0;
            rresp_q <= eao_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_q <= 1'h1;
            rresp_q <= rd_hit ? eao_pkg::RESP_OKAY : eao_pkg::RESP_SLVERR;
            rdata_q <= rd_word;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'h0;
        end
    end
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = rdata_q;
    // Exposure state. Events of the other shutter mode are ignored altogether.
    assign start_ev = (shutter_q == eao_pkg::EAO_SHUTTER_ROLLING) ?
                      first_line_exp_start_i : frame_exp_start_i; // see [RULE_05] [RULE_01] [RULE_03]
    assign end_ev = (shutter_q == eao_pkg::EAO_SHUTTER_ROLLING) ?
                    last_line_exp_end_i : frame_exp_end_i; // see [RULE_05] [RULE_02] [RULE_04]
    // A mode switch mid-frame would leave no matching end event, so it ends the pulse.
    assign mode_chg = wr_lane0 && (wr_ofs == eao_pkg::OFS_SHUTTER) &&
                      (w_data_q[eao_pkg::SHUTTER_BIT] != shutter_q);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            exp_q <= 1'h0; // see [RULE_12]
        end else if (start_ev && !mode_chg) begin
            // A new frame starting in the cycle the last one ends keeps the level high.
            exp_q <= 1'h1; // see [RULE_01] [RULE_03]
        end else if (end_ev || mode_chg) begin
            exp_q <= 1'h0; // see [RULE_02] [RULE_04] [RULE_12]
        end
    end
    // Saturating idle run length, so the idle check needs no long repetition.
    always_ff @(posedge clk_i) begin
        if (srst_i || exp_q) begin
            idle_cnt_q <= '0;
        end else if (idle_cnt_q != IDLE_W'(LAG_CYCLES)) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end
    // Any offset the sensor adds is absorbed upstream of the event pulses.
    eao_lag #(
        .DEPTH(LAG_CYCLES)
    ) u_lag (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i(exp_q),
        .q_o(exp_lag)
    ); // see [RULE_06]
    assign exposure_in_progress_out_o = exp_lag;
    // Line routing, registered so the pins never glitch on a source change.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            line_one_q <= 1'h0;
            line_two_q <= 1'h0;
            line_two_oe_q <= 1'h0;
        end else begin
            line_one_q <= (origin_one_q == eao_pkg::EAO_ORIGIN_EXPOSURE) && exp_lag; // see [RULE_07]
            line_two_q <= (origin_two_q == eao_pkg::EAO_ORIGIN_EXPOSURE) && exp_lag; // see [RULE_07]
            line_two_oe_q <= dir_two_q; // see [RULE_10]
        end
    end
    assign output_line_one_o = line_one_q;
    assign bidirectional_line_two_o = line_two_q;
    assign bidirectional_line_two_oe_o = line_two_oe_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_rise_seen;
        $rose(exp_q);
    endsequence
    sequence s_out_rises;
        ##LAG_I $rose(exposure_in_progress_out_o);
    endsequence
    AST_GLOBAL_RISE: assert property ( // see [RULE_01]
        shutter_q == eao_pkg::EAO_SHUTTER_GLOBAL && frame_exp_start_i && !mode_chg |=> exp_q)
        else $error("Global frame start did not raise exposure");
    AST_GLOBAL_FALL: assert property ( // see [RULE_02]
        shutter_q == eao_pkg::EAO_SHUTTER_GLOBAL && frame_exp_end_i && !frame_exp_start_i
        |=> !exp_q)
        else $error("Global frame end did not lower exposure");
    AST_ROLL_RISE: assert property ( // see [RULE_03]
        shutter_q == eao_pkg::EAO_SHUTTER_ROLLING && first_line_exp_start_i && !mode_chg
        |=> exp_q)
        else $error("First line start did not raise exposure");
    AST_ROLL_HOLD: assert property ( // see [RULE_04]
        shutter_q == eao_pkg::EAO_SHUTTER_ROLLING && exp_q && !last_line_exp_end_i && !mode_chg
        |=> exp_q)
        else $error("Rolling exposure fell before the last line ended");
    AST_MODE_IGNORE: assert property ( // see [RULE_05]
        shutter_q == eao_pkg::EAO_SHUTTER_GLOBAL && !exp_q && !frame_exp_start_i
        |=> !exp_q)
        else $error("Exposure rose without a global frame start");
    AST_LAG: assert property ( // see [RULE_06]
        s_rise_seen |-> s_out_rises)
        else $error("Exposure output edge did not follow after the lag");
    AST_ROUTE_ONE: assert property ( // see [RULE_07]
        output_line_one_o |-> $past(origin_one_q == eao_pkg::EAO_ORIGIN_EXPOSURE) && $past(exp_lag))
        else $error("Line one high without exposure routed to it");
    AST_ROUTE_TWO: assert property ( // see [RULE_07]
        $rose(exp_q) && origin_two_q == eao_pkg::EAO_ORIGIN_EXPOSURE &&
        $stable(origin_two_q) |-> ##LAG_P1 (bidirectional_line_two_o ||
        origin_two_q != eao_pkg::EAO_ORIGIN_EXPOSURE || !$past(exp_lag)))
        else $error("Line two missed the routed exposure level");
    AST_DIR_TWO: assert property ( // see [RULE_10]
        bidirectional_line_two_oe_o |-> $past(dir_two_q))
        else $error("Line two driven while set as input");
    AST_IDLE_LOW: assert property ( // see [RULE_12]
        idle_cnt_q == IDLE_W'(LAG_CYCLES) |-> !exposure_in_progress_out_o)
        else $error("Exposure output high with no exposure in progress");
    AST_BRESP: assert property (
        do_wr |=> bvalid_q && bresp_q == (($past(wr_hit)) ? eao_pkg::RESP_OKAY : eao_pkg::RESP_SLVERR))
        else $error("Write response missing or wrong");
endmodule : eao_top

// ---- tb_top.sv ----
// Self-checking testbench for the exposure active output block.
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned LAG = 3;
    logic clk_i, srst_i, fs, fe, ls, le, l1, l2i, l2o, l2oe, exo, far;
    logic [7:0] flashes, width;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int errors, comparisons;

    eao_top #(.LAG_CYCLES(LAG)) eao_top_i (.clk_i(clk_i), .srst_i(srst_i),
        .frame_exp_start_i(fs), .frame_exp_end_i(fe), .first_line_exp_start_i(ls),
        .last_line_exp_end_i(le), .output_line_one_o(l1), .bidirectional_line_two_i(l2i),
        .bidirectional_line_two_o(l2o), .bidirectional_line_two_oe_o(l2oe),
        .exposure_in_progress_out_o(exo), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    eao_flash_model eao_flash_model_i (.clk_i(clk_i), .srst_i(srst_i), .line_i(l1),
        .flashes_o(flashes), .width_o(width), .far_drive_o(far));

    assign l2i = l2oe ? l2o : far;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task timeout(input string what);
        errors++;
        $display("[FAIL] %s expected answer seen timeout", what);
        final_report();
    endtask : timeout

    task axi_wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 64) timeout("write");
        bready <= 1'b0;
        chk("bresp", eao_pkg::RESP_OKAY, bresp);
    endtask : axi_wr

    task rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp,
                input logic [1:0] exp_resp);
        int n;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 64) timeout(what);
        rready <= 1'b0;
        chk(what, exp, rdata);
        chk("rresp", exp_resp, rresp);
    endtask : rd_chk

    // Sensor events are one-cycle pulses, sampled at the edge that ends them.
    // Any automatic sensor exposure offset is already folded into the pulse times.
    task pulse(input int which);
        @(posedge clk_i);
        fs <= (which == 0);
        fe <= (which == 1);
        ls <= (which == 2);
        le <= (which == 3);
        @(posedge clk_i);
        fs <= 1'b0;
        fe <= 1'b0;
        ls <= 1'b0;
        le <= 1'b0;
    endtask : pulse

    task lag_chk(input logic lvl, input logic two);
        repeat (LAG - 1) @(posedge clk_i);
        #1;
        chk("exp_out_early", !lvl, exo);
        @(posedge clk_i);
        #1;
        chk("exp_out", lvl, exo);
        @(posedge clk_i);
        #1;
        chk("line_one", lvl, l1);
        if (two) chk("line_two", lvl, l2i);
    endtask : lag_chk

    // Events of the other shutter mode are offered just before the real ones and must be ignored.
    task frame(input logic rolling, input logic two, input logic [7:0] n);
        int s;
        s = rolling ? 2 : 0;
        pulse(2 - s);
        pulse(s);
        lag_chk(1'b1, two);
        pulse(3 - s);
        pulse(s + 1);
        lag_chk(1'b0, two);
        @(posedge clk_i);
        #1;
        chk("exp_out_idle", 0, exo);
        chk("flash_width", LAG + 5, width);
        chk("flash_count", n, flashes);
    endtask : frame

    task t_reset();
        chk("exp_out_reset", 0, exo);
        chk("line_one_reset", 0, l1);
        chk("line_two_oe_reset", 0, l2oe);
        rd_chk("shutter", eao_pkg::OFS_SHUTTER, 32'h0, eao_pkg::RESP_OKAY);
        rd_chk("picker", eao_pkg::OFS_PICKER, 32'h0, eao_pkg::RESP_OKAY);
        rd_chk("line_cfg", eao_pkg::OFS_LINE_CFG, 32'h1, eao_pkg::RESP_OKAY);
        rd_chk("unmapped", 5'h10, 32'h0, eao_pkg::RESP_SLVERR);
        $display("test reset done");
    endtask : t_reset

    task t_global();
        axi_wr(eao_pkg::OFS_PICKER, 32'h0);
        axi_wr(eao_pkg::OFS_LINE_CFG, 32'h10);
        frame(1'b0, 1'b0, 8'h01);
        $display("test global done");
    endtask : t_global

    task t_rolling();
        axi_wr(eao_pkg::OFS_SHUTTER, 32'h1);
        rd_chk("shutter", eao_pkg::OFS_SHUTTER, 32'h1, eao_pkg::RESP_OKAY);
        frame(1'b1, 1'b0, 8'h02);
        $display("test rolling done");
    endtask : t_rolling

    task t_line_two();
        axi_wr(eao_pkg::OFS_PICKER, 32'h1);
        axi_wr(eao_pkg::OFS_LINE_CFG, 32'h1);
        // The enable register loads at the response edge, so look just after it.
        #1;
        chk("line_two_oe", 1, l2oe);
        axi_wr(eao_pkg::OFS_LINE_CFG, 32'h11);
        rd_chk("line_cfg", eao_pkg::OFS_LINE_CFG, 32'h11, eao_pkg::RESP_OKAY);
        frame(1'b1, 1'b1, 8'h03);
        rd_chk("status", eao_pkg::OFS_STATUS, 32'h8, eao_pkg::RESP_OKAY);
        $display("test line two done");
    endtask : t_line_two

    initial begin
        errors = 0;
        comparisons = 0;
        srst_i = 1'b1;
        {fs, fe, ls, le} = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 5'h00;
        araddr = 5'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset();
        t_global();
        t_rolling();
        t_line_two();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        timeout("run");
    end
endmodule : tb_top
